// file: rtl/ps2_channel_pkg.sv
// Constants, register map and carrier types of the PS/2 channel controller.
// What this block does
// - Enabled receive mode floats clock and data quickly.
// - Setting transmit select pulls clock low.
// - Transmit write drives start bit 45-90 ns.
// - Transmit write releases clock 90-130 ns.
// - Released clock clears transmit idle within 1.7 us.
// - Data changes within 1 us after falling clock.
// - Select clears 3.5-7.1 us after last rise.
// - Idle flag sets within 500 ns of select clear.
// - Transmit idle set raises an interrupt.
// - Select low releases the data line, except in TX_WAIT and TX_SHIFT.
// - Receive samples data on each falling clock.
// - Ready flag sets within 1.6 us of 11th fall.
// - Receive register read clears ready flag.
// - Clock held low until receive register read.
// - Ready flag set raises an interrupt.
// - Disabled channel drives clock low, data floats.
`default_nettype none
package ps2_channel_pkg;
    // Clock rate in kHz, used to turn times into cycle counts.
    localparam int ClkKhz = 125000;
    // Start-bit delay after a transmit write, in ns (window 45..90).
    localparam int StartDelayNs = 60;
    localparam int StartDelayCyc = (StartDelayNs * ClkKhz + 999999) / 1000000;
    // Clock-release delay after a transmit write, in ns (window 90..130).
    localparam int ReleaseDelayNs = 100;
    localparam int ReleaseDelayCyc = (ReleaseDelayNs * ClkKhz + 999999) / 1000000;
    // End-of-transmit delay before select clears, in ns (window 3.5..7.1 us).
    localparam int EndDelayNs = 4000;
    localparam int EndDelayCyc = (EndDelayNs * ClkKhz + 999999) / 1000000;
    localparam int CntW = 10;
    // Wishbone word offsets (byte addresses).
    localparam logic [3:0] CtrlAddr = 4'h0;
    localparam logic [3:0] StatAddr = 4'h4;
    localparam logic [3:0] TxAddr = 4'h8;
    localparam logic [3:0] RxAddr = 4'hC;
    // Control register field positions.
    localparam int CtrlEnBit = 0;
    localparam int CtrlTrBit = 1;
    // Status register field positions.
    localparam int StatIdleBit = 0;
    localparam int StatRdyBit = 1;
    localparam int StatParErrBit = 2;
    localparam int StatIrqBit = 3;
    // Frame length in clocked bits.
    localparam logic [3:0] FrameBits = 4'hB;
    localparam logic [3:0] ParityIdx = 4'hA;
    // Transmitter states.
    typedef enum logic [2:0] {TX_OFF, TX_INHIBIT, TX_WAIT, TX_SHIFT, TX_END} txState_e;
    // Open-drain pin drive pair per line: output value, active-low enable.
    typedef struct packed {
        logic clkOut;
        logic clkOe_n;
        logic datOut;
        logic datOe_n;
    } pinDrive_s;
endpackage
`default_nettype wire

// file: rtl/ps2_channel_controller.sv
// PS/2 channel controller with a classic Wishbone register slave.
//
// Decided for this implementation: the address map and register access over Wishbone.
`default_nettype none
module ps2_channel_controller (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic serialClockIn,
    output logic serialClockOut,
    output logic serialClockOe_n,
    input wire logic serialDataIn,
    output logic serialDataOut,
    output logic serialDataOe_n,
    output logic irq
);
    // Two-stage synchronisers for both pins.
    logic clkMeta_ff, clkSync_ff, clkPrev_ff;
    logic datMeta_ff, datSync_ff;
    // Control bits written by firmware.
    logic enable_ff, trSel_ff;
    // Status flags.
    logic idle_ff, rdy_ff, parErr_ff;
    // Transmit shift data and receive data.
    logic [7:0] txData_ff, rxData_ff;
    logic [10:0] rxShift_ff;
    logic [3:0] bitCnt_ff;
    // Width of the shared delay counter, taken from the package.
    localparam int DelayW = ps2_channel_pkg::CntW;
    // Delay counter shared by the start, release and end-of-frame waits.
    logic [DelayW-1:0] delay_ff;
    logic rxHold_ff;
    logic startSeen_ff;
    ps2_channel_pkg::txState_e state_ff;
    ps2_channel_pkg::pinDrive_s pins_ff;
    logic [31:0] rdData_ff;
    logic ack_ff;
    logic irq_ff;
    logic idlePrev_ff, rdyPrev_ff;
    localparam logic [DelayW-1:0] StartCnt = DelayW'(ps2_channel_pkg::StartDelayCyc);
    localparam logic [DelayW-1:0] RelCnt = DelayW'(ps2_channel_pkg::ReleaseDelayCyc);
    localparam logic [DelayW-1:0] EndCnt = DelayW'(ps2_channel_pkg::EndDelayCyc);

    // Odd parity of a byte, used by both directions.
    function automatic logic oddPar(input logic [7:0] d);
        oddPar = ~^d;
    endfunction

    // Bus decode as named wires.
    wire busReq = wb_cyc_i & wb_stb_i & ~ack_ff;
    wire wrLow = busReq & wb_we_i & wb_sel_i[0];
    wire ctrlWr = wrLow & (wb_adr_i == ps2_channel_pkg::CtrlAddr);
    wire txWr = wrLow & (wb_adr_i == ps2_channel_pkg::TxAddr);
    wire rxRd = busReq & ~wb_we_i & (wb_adr_i == ps2_channel_pkg::RxAddr);
    wire clkFall = clkPrev_ff & ~clkSync_ff;
    wire clkRise = ~clkPrev_ff & clkSync_ff;
    // A transmit write is honoured only while inhibiting with the select set.
    wire txStart = txWr & (state_ff == ps2_channel_pkg::TX_INHIBIT);
    wire txDone = (state_ff == ps2_channel_pkg::TX_END) & (delay_ff == '0);
    wire [3:0] rxCntNext = bitCnt_ff + 4'h1;
    wire rxFrameEnd = enable_ff & ~trSel_ff & ~rxHold_ff & clkFall
                      & (rxCntNext == ps2_channel_pkg::FrameBits);
    // Transmit bit chosen by position: start, data, parity, stop.
    wire txBit = (bitCnt_ff == 4'h0) ? 1'b0 :
                 (bitCnt_ff < 4'h9) ? txData_ff[bitCnt_ff[2:0] - 3'h1] :
                 (bitCnt_ff == 4'h9) ? oddPar(txData_ff) : 1'b1;
    // Read multiplexer, unmapped addresses read zero.
    wire [31:0] ctrlVal = {30'h0, trSel_ff, enable_ff};
    wire [31:0] statVal = {28'h0, irq_ff, parErr_ff, rdy_ff, idle_ff};
    wire [31:0] rdMux = (wb_adr_i == ps2_channel_pkg::CtrlAddr) ? ctrlVal :
                        (wb_adr_i == ps2_channel_pkg::StatAddr) ? statVal :
                        (wb_adr_i == ps2_channel_pkg::TxAddr) ? {24'h0, txData_ff} :
                        (wb_adr_i == ps2_channel_pkg::RxAddr) ? {24'h0, rxData_ff} : 32'h0;

    // Pin synchronisers; the first stage feeds only the second.
    always_ff @(posedge ref_clk) begin
        clkMeta_ff <= serialClockIn;
        clkSync_ff <= clkMeta_ff;
        clkPrev_ff <= clkSync_ff;
        datMeta_ff <= serialDataIn;
        datSync_ff <= datMeta_ff;
    end

    // Wishbone slave: one-cycle acknowledge, dropped the cycle after.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
            rdData_ff <= 32'h0;
        end else begin
            ack_ff <= busReq;
            rdData_ff <= busReq ? rdMux : 32'h0;
        end
    end

    // Control register; hardware clearing of the select wins over firmware.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            enable_ff <= 1'b0;
            trSel_ff <= 1'b0;
        end else begin
            if (ctrlWr) begin
                enable_ff <= wb_dat_i[ps2_channel_pkg::CtrlEnBit];
                trSel_ff <= wb_dat_i[ps2_channel_pkg::CtrlTrBit];
            end
            if (txDone) begin
                trSel_ff <= 1'b0;
            end
        end
    end

    // Transmitter sequencer with its delay counter.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            state_ff <= ps2_channel_pkg::TX_OFF;
            delay_ff <= '0;
            txData_ff <= 8'h0;
            startSeen_ff <= 1'b0;
        end else begin
            if (delay_ff != '0) begin
                delay_ff <= delay_ff - DelayW'(1);
            end
            case (state_ff)
                ps2_channel_pkg::TX_OFF: begin
                    // Select set while enabled: go inhibit the peripheral.
                    if (enable_ff && trSel_ff) begin
                        state_ff <= ps2_channel_pkg::TX_INHIBIT;
                    end
                end
                ps2_channel_pkg::TX_INHIBIT: begin
                    if (!enable_ff || !trSel_ff) begin
                        state_ff <= ps2_channel_pkg::TX_OFF;
                    end else if (txStart) begin
                        txData_ff <= wb_dat_i[7:0];
                        delay_ff <= RelCnt;
                        startSeen_ff <= 1'b0;
                        state_ff <= ps2_channel_pkg::TX_WAIT;
                    end
                end
                ps2_channel_pkg::TX_WAIT: begin
                    // Clock released once the release delay runs out.
                    if (delay_ff == '0) begin
                        state_ff <= ps2_channel_pkg::TX_SHIFT;
                    end
                end
                ps2_channel_pkg::TX_SHIFT: begin
                    // The peripheral's eleventh rising edge ends the frame.
                    if (clkRise && startSeen_ff && bitCnt_ff == ps2_channel_pkg::FrameBits) begin
                        delay_ff <= EndCnt;
                        state_ff <= ps2_channel_pkg::TX_END;
                    end
                    if (clkFall) begin
                        startSeen_ff <= 1'b1;
                    end
                end
                ps2_channel_pkg::TX_END: begin
                    if (delay_ff == '0) begin
                        state_ff <= ps2_channel_pkg::TX_OFF;
                    end
                end
                default: begin
                    state_ff <= ps2_channel_pkg::TX_OFF;
                end
            endcase
            // Disabling the channel aborts any transmit at once.
            if (!enable_ff) begin
                state_ff <= ps2_channel_pkg::TX_OFF;
            end
        end
    end

    // Bit counter shared by both directions, advanced on falling clock edges.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            bitCnt_ff <= 4'h0;
        end else if (!enable_ff || state_ff == ps2_channel_pkg::TX_INHIBIT
                     || state_ff == ps2_channel_pkg::TX_END
                     || rxFrameEnd || rxHold_ff) begin
            // Cleared after a transmit too, so a later reception starts at zero.
            bitCnt_ff <= 4'h0;
        end else if (clkFall && bitCnt_ff != ps2_channel_pkg::FrameBits) begin
            bitCnt_ff <= rxCntNext;
        end
    end

    // Receive shift register and data capture, least significant bit first.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            rxShift_ff <= 11'h0;
            rxData_ff <= 8'h0;
            parErr_ff <= 1'b0;
        end else if (enable_ff && !trSel_ff && !rxHold_ff && clkFall) begin
            rxShift_ff <= {datSync_ff, rxShift_ff[10:1]};
            if (rxFrameEnd) begin
                // Byte sits in bits 2..9 while the stop bit is shifting in
                rxData_ff <= rxShift_ff[9:2];
                parErr_ff <= (oddPar(rxShift_ff[9:2]) != rxShift_ff[10]) | ~datSync_ff;
            end
        end
    end

    // Status flags; a new frame setting ready wins over a clearing read.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            idle_ff <= 1'b1;
            rdy_ff <= 1'b0;
            rxHold_ff <= 1'b0;
        end else begin
            if (state_ff == ps2_channel_pkg::TX_WAIT && delay_ff == '0) begin
                idle_ff <= 1'b0;
            end else if (txDone) begin
                idle_ff <= 1'b1;
            end
            if (rxFrameEnd) begin
                rdy_ff <= 1'b1;
                rxHold_ff <= 1'b1;
            end else if (rxRd) begin
                rdy_ff <= 1'b0;
                rxHold_ff <= 1'b0;
            end
            if (!enable_ff) begin
                rxHold_ff <= 1'b0;
            end
        end
    end

    // Interrupt pulses on the rising edge of either flag.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            idlePrev_ff <= 1'b1;
            rdyPrev_ff <= 1'b0;
            irq_ff <= 1'b0;
        end else begin
            idlePrev_ff <= idle_ff;
            rdyPrev_ff <= rdy_ff;
            irq_ff <= (idle_ff & ~idlePrev_ff) | (rdy_ff & ~rdyPrev_ff);
        end
    end

    // Pin drivers: lines are only pulled low, never driven high.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            pins_ff <= '{clkOut: 1'b0, clkOe_n: 1'b0, datOut: 1'b0, datOe_n: 1'b1};
        end else begin
            pins_ff.clkOut <= 1'b0;
            pins_ff.datOut <= 1'b0;
            if (!enable_ff) begin
                pins_ff.clkOe_n <= 1'b0;
                pins_ff.datOe_n <= 1'b1;
            end else if (state_ff == ps2_channel_pkg::TX_INHIBIT) begin
                pins_ff.clkOe_n <= 1'b0;
                pins_ff.datOe_n <= 1'b1;
            end else if (state_ff == ps2_channel_pkg::TX_WAIT) begin
                // Start bit low early, clock held until the release delay ends.
                pins_ff.clkOe_n <= (delay_ff == '0);
                pins_ff.datOe_n <= (delay_ff > RelCnt - StartCnt);
            end else if (state_ff == ps2_channel_pkg::TX_SHIFT) begin
                pins_ff.clkOe_n <= 1'b1;
                // Next bit put out right after the falling edge
                pins_ff.datOe_n <= (bitCnt_ff >= ps2_channel_pkg::FrameBits - 4'h1) | txBit;
            end else if (state_ff == ps2_channel_pkg::TX_END || trSel_ff) begin
                pins_ff.clkOe_n <= 1'b1;
                pins_ff.datOe_n <= 1'b1;
            end else begin
                pins_ff.clkOe_n <= ~rxHold_ff;
                pins_ff.datOe_n <= 1'b1;
            end
        end
    end

    assign wb_dat_o = rdData_ff;
    assign wb_ack_o = ack_ff;
    assign irq = irq_ff;
    assign serialClockOut = pins_ff.clkOut;
    assign serialClockOe_n = pins_ff.clkOe_n;
    assign serialDataOut = pins_ff.datOut;
    assign serialDataOe_n = pins_ff.datOe_n;
endmodule
`default_nettype wire

// file: sim/ps2_channel_checker.sv
// Port-level concurrent checks for the PS/2 channel controller.
`default_nettype none
module ps2_channel_checker (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic wb_ack_o,
    input wire logic serialClockOut,
    input wire logic serialClockOe_n,
    input wire logic serialDataOut,
    input wire logic serialDataOe_n,
    input wire logic irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    // Accesses are judged at the edge that completes them.
    wire logic wrDone = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o & wb_sel_i[0];
    wire logic rdDone = wb_cyc_i & wb_stb_i & !wb_we_i & wb_ack_o;
    wire logic ctlWr = wrDone && (wb_adr_i == ps2_channel_pkg::CtrlAddr);
    wire logic txWr = wrDone && (wb_adr_i == ps2_channel_pkg::TxAddr);
    wire logic rxRd = rdDone && (wb_adr_i == ps2_channel_pkg::RxAddr);
    logic enable_ff; // Shadow of the enable bit as last written.
    logic select_ff; // Shadow of the select bit; the hardware clear is not seen here.
    // Firmware view of the control bits, enough to qualify the checks below.
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            enable_ff <= 1'h0;
            select_ff <= 1'h0;
        end else if (ctlWr) begin
            enable_ff <= wb_dat_i[ps2_channel_pkg::CtrlEnBit];
            select_ff <= wb_dat_i[ps2_channel_pkg::CtrlTrBit];
        end
    end
    // Steps of a transmit start: data and clock first keep their old state.
    sequence s_dataIdle; serialDataOe_n[*6]; endsequence
    sequence s_clkHeld; (!serialClockOe_n)[*8]; endsequence
    a_open_drain: assert property (!serialClockOut && !serialDataOut)
        else $error("Serial line driven high");
    a_off_pattern: assert property ((!enable_ff)[*4] |-> !serialClockOe_n && serialDataOe_n)
        else $error("Disabled channel pin pattern wrong");
    a_rx_float: assert property ($rose(enable_ff && !select_ff) |-> ##[1:125]
        (serialClockOe_n && serialDataOe_n)) else $error("Lines not floated in receive mode");
    a_tx_inhibit: assert property ($rose(enable_ff && select_ff) |-> ##[1:4] !serialClockOe_n)
        else $error("Clock not inhibited on select");
    a_start_bit: assert property (txWr && enable_ff && select_ff |-> s_dataIdle ##[1:6]
        !serialDataOe_n) else $error("Start bit outside its window");
    a_clk_release: assert property (txWr && enable_ff && select_ff |-> s_clkHeld ##[5:9]
        serialClockOe_n) else $error("Clock release outside its window");
    a_rx_hold: assert property (irq && enable_ff && !select_ff |-> !serialClockOe_n)
        else $error("Clock not held after reception");
    a_rx_release: assert property (rxRd && enable_ff && !select_ff |-> ##[1:62]
        serialClockOe_n) else $error("Clock not released after receive read");
    a_irq_pulse: assert property (irq |=> !irq)
        else $error("Interrupt longer than one cycle");
endmodule
bind ps2_channel_controller ps2_channel_checker ps2_channel_checker_inst (
    .ref_clk, .reset_n, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
    .wb_ack_o, .serialClockOut, .serialClockOe_n, .serialDataOut, .serialDataOe_n, .irq
);
`default_nettype wire

// file: sim/ps2_peripheral_model.sv
// Behavioural PS/2 peripheral that clocks frames in both directions.
`default_nettype none
module ps2_peripheral_model (
    input wire logic lineClk,
    input wire logic lineDat,
    output logic clkRel,
    output logic datRel
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam real Half = 62.5; // Half of the 125 ns link clock.
    // Lines are only pulled low; released they rest high on the pull-ups.
    initial begin
        clkRel = 1'h1;
        datRel = 1'h1;
    end
    // One clock pulse; the clock stands high between frames.
    task automatic pulse();
        #Half clkRel = 1'h0;
        #Half clkRel = 1'h1;
    endtask
    // Sends a frame; data is set in the high phase, well clear of the fall.
    task automatic send_frame(input logic [7:0] b, input logic badPar);
        logic [10:0] f;
        f = {1'h1, (~^b) ^ badPar, b, 1'h0};
        for (int i = 0; i < 11; i++) begin
            datRel = f[i];
            pulse();
        end
        datRel = 1'h1;
    endtask
    // Takes a frame from the controller and acknowledges it on clock eleven.
    task automatic recv_frame(output logic [10:0] f, output logic ok);
        ok = 1'h0;
        for (int n = 0; n < 400 && !ok; n++) begin
            #10;
            ok = (lineClk === 1'h1) && (lineDat === 1'h0);
        end
        #2000; // Earliest answer to a start bit.
        f[0] = lineDat;
        for (int i = 1; i < 11; i++) begin
            pulse();
            f[i] = lineDat; // Sampled after the rising edge.
        end
        datRel = 1'h0;
        pulse();
        datRel = 1'h1;
    endtask
endmodule
`default_nettype wire

// file: sim/ps2_channel_controller_tb.sv
// Self-checking bench for the PS/2 channel controller over Wishbone.
`default_nettype none
module ps2_channel_controller_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'h0;
    logic reset_n = 1'h0;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [3:0] adr = 4'h0;
    logic [31:0] datW = 32'h0;
    logic [31:0] datR, rd;
    logic ack, clkOut, clkOe_n, datOut, datOe_n, irq, clkRel, datRel, ok;
    logic [10:0] fr;
    wire clkLine, datLine;
    int err_total = 0, compares = 0, irqCnt = 0, n, s;
    // Wired-AND of both parties with pull-ups.
    assign clkLine = (clkOe_n ? 1'h1 : clkOut) & clkRel;
    assign datLine = (datOe_n ? 1'h1 : datOut) & datRel;
    always #4 ref_clk = ~ref_clk;
    // Interrupt pulses are counted away from the launching edge.
    always @(negedge ref_clk) if (irq === 1'h1) irqCnt++;
    ps2_channel_controller ps2_channel_controller_inst (.ref_clk(ref_clk), .reset_n(reset_n),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(datW), .wb_dat_o(datR), .wb_ack_o(ack), .serialClockIn(clkLine),
        .serialClockOut(clkOut), .serialClockOe_n(clkOe_n), .serialDataIn(datLine),
        .serialDataOut(datOut), .serialDataOe_n(datOe_n), .irq(irq));
    ps2_peripheral_model ps2_peripheral_model_inst (.lineClk(clkLine), .lineDat(datLine),
        .clkRel(clkRel), .datRel(datRel));
    task automatic print_verdict();
        $display("Compares %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One classic cycle, held until ack is seen, released after that edge.
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        datW <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (ack !== 1'h1 && n < 50);
        if (ack !== 1'h1) begin
            err_total++;
            print_verdict();
        end
        rd = datR;
        cyc <= 1'h0;
        stb <= 1'h0;
    endtask
    task automatic rdchk(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m);
        wb(1'h0, a, 32'h0);
        chk(rd & m, exp);
    endtask
    // Waits for an interrupt beyond count s, bounded; n holds the cycles spent.
    task automatic wait_irq(input int lim);
        n = 0;
        while (irqCnt == s) begin
            @(negedge ref_clk);
            n++;
            if (n > lim) begin
                err_total++;
                print_verdict();
            end
        end
    endtask
    initial begin
        repeat (20) @(posedge ref_clk);
        reset_n <= 1'h1;
        rdchk(ps2_channel_pkg::StatAddr, 32'h1, 32'hFFFFFFFF);
        chk({30'h0, clkOe_n, datOe_n}, 32'h1);
        wb(1'h1, 4'h6, 32'hFF);
        rdchk(4'h6, 32'h0, 32'hFFFFFFFF);
        rdchk(ps2_channel_pkg::CtrlAddr, 32'h0, 32'hFFFFFFFF);
        $display("Test reset and map done");
        wb(1'h1, ps2_channel_pkg::CtrlAddr, 32'h1);
        repeat (125) @(negedge ref_clk);
        chk({30'h0, clkOe_n, datOe_n}, 32'h3);
        // A good frame, then one with its parity turned round.
        for (int k = 0; k < 2; k++) begin
            s = irqCnt;
            ps2_peripheral_model_inst.send_frame(k ? 8'h3C : 8'hA5, k[0]);
            wait_irq(190);
            rdchk(ps2_channel_pkg::StatAddr, 32'h3 | (k << 2), 32'h7);
            chk({31'h0, clkOe_n}, 32'h0);
            rdchk(ps2_channel_pkg::RxAddr, k ? 32'h3C : 32'hA5, 32'hFF);
            repeat (63) @(negedge ref_clk);
            rdchk(ps2_channel_pkg::StatAddr, 32'h1, 32'h3);
            chk({31'h0, clkOe_n}, 32'h1);
        end
        $display("Test receive done");
        wb(1'h1, ps2_channel_pkg::CtrlAddr, 32'h3);
        repeat (4) @(negedge ref_clk);
        chk({31'h0, clkOe_n}, 32'h0);
        wb(1'h1, ps2_channel_pkg::TxAddr, 32'h5A);
        fork
            ps2_peripheral_model_inst.recv_frame(fr, ok);
            begin
                repeat (228) @(negedge ref_clk);
                rdchk(ps2_channel_pkg::StatAddr, 32'h0, 32'h1);
            end
        join
        chk({31'h0, ok}, 32'h1);
        chk({21'h0, fr}, {21'h0, 1'h1, ~^8'h5A, 8'h5A, 1'h0});
        s = irqCnt;
        wait_irq(950);
        chk({31'h0, n >= 437}, 32'h1);
        rdchk(ps2_channel_pkg::CtrlAddr, 32'h1, 32'h3);
        rdchk(ps2_channel_pkg::StatAddr, 32'h1, 32'h3);
        chk({31'h0, datOe_n}, 32'h1);
        $display("Test transmit done");
        wb(1'h1, ps2_channel_pkg::CtrlAddr, 32'h0);
        repeat (4) @(negedge ref_clk);
        chk({30'h0, clkOe_n, datOe_n}, 32'h1);
        $display("Test disable done");
        print_verdict();
    end
endmodule
`default_nettype wire
